/* File: hw/dkc_top.sv */
// Disk unit channel interface: normal channel words to and from up to eight disk units
`timescale 1ns/1ps
module dkc_top #(
   parameter int FLAG_CYCLES = dkc_pkg::FLAG_CYC,
   parameter int MARK_CYCLES = dkc_pkg::MARK_CYC,
   parameter int ONSEC_CYCLES = dkc_pkg::ONSEC_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [dkc_pkg::WORD_W-1:0] tag_select_word_in,
   input wire logic [dkc_pkg::WORD_W-1:0] drive_control_word_in,
   input wire logic [dkc_pkg::WORD_W-1:0] write_word_in,
   output logic [dkc_pkg::WORD_W-1:0] drive_status_word_out,
   output logic [dkc_pkg::WORD_W-1:0] read_word_out,
   output logic [dkc_pkg::UNIT_W-1:0] unit_select_out,
   output logic [dkc_pkg::BUS_W-1:0] addr_ctrl_bus_out,
   output logic head_tag_out,
   output logic sector_tag_out,
   output logic diff_tag_out,
   output logic ctrl_tag_out,
   output logic write_data_out,
   input wire logic [dkc_pkg::UNITS-1:0] unit_selected_in,
   input wire logic ready_in,
   input wire logic seek_error_in,
   input wire logic on_cylinder_in,
   input wire logic on_sector_in,
   input wire logic fault_in,
   input wire logic sector_mark_in,
   input wire logic index_mark_in,
   input wire logic read_data_in,
   input wire logic bit_clock_in
);
   import dkc_pkg::*;

   // ************************************************
   // Drive line synchronisers
   // ************************************************
   localparam int SY_W = UNITS + 9;
   localparam int SY_BCLK = 0;
   localparam int SY_RDAT = 1;
   localparam int SY_IMARK = 2;
   localparam int SY_SMARK = 3;
   localparam int SY_FAULT = 4;
   localparam int SY_ONSEC = 5;
   localparam int SY_ONCYL = 6;
   localparam int SY_SEEK = 7;
   localparam int SY_READY = 8;
   localparam int SY_UNIT = 9;

   wire [SY_W-1:0] drv_raw = {unit_selected_in, ready_in, seek_error_in, on_cylinder_in,
      on_sector_in, fault_in, sector_mark_in, index_mark_in, read_data_in, bit_clock_in};

   logic [SY_W-1:0] sync_a;
   logic [SY_W-1:0] sync_b;
   logic [SY_W-1:0] sync_c;

   // Third stage only feeds edge detection, never the first stage
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
      end else begin
         sync_a <= drv_raw;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   wire bit_stb = sync_b[SY_BCLK] & ~sync_c[SY_BCLK];
   wire rd_bit = sync_b[SY_RDAT];
   wire smark_rise = sync_b[SY_SMARK] & ~sync_c[SY_SMARK];
   wire imark_rise = sync_b[SY_IMARK] & ~sync_c[SY_IMARK];
   wire onsec_rise = sync_b[SY_ONSEC] & ~sync_c[SY_ONSEC];

   // ************************************************
   // Channel switch and control decode
   // ************************************************
   wire [1:0] sw_code = {tag_select_word_in[TG_SW1], tag_select_word_in[TG_SW0]};
   wire chan_on = (sw_code == SW_DISK);
   wire [WORD_W-1:0] ctl = chan_on ? drive_control_word_in : WORD_ZERO;
   wire [WORD_W-1:0] tag = chan_on ? tag_select_word_in : WORD_ZERO;

   wire [BUS_W-1:0] bus_raw = ctl[CT_BUS_LSB +: BUS_W];
   wire rst_flag = ctl[CT_RSTFLAG];
   wire hold_sm = ctl[CT_HOLDSM];
   wire hold_im = ctl[CT_HOLDIM];
   wire write_mode = ctl[CT_WRITE];
   wire zsearch = ctl[CT_ZSEARCH];
   wire [UNIT_W-1:0] unit_code = ctl[CT_UNIT_LSB +: UNIT_W];

   // ************************************************
   // Tag line selection and bus masking
   // ************************************************
   // Several tags at once is a controller slip; the strongest one wins
   wire sel_ctrl = tag[TG_CTRL];
   wire sel_diff = tag[TG_DIFF] & ~sel_ctrl;
   wire sel_head = tag[TG_HEAD] & ~sel_ctrl & ~tag[TG_DIFF];
   wire sel_sect = tag[TG_SECT] & ~sel_ctrl & ~tag[TG_DIFF] & ~tag[TG_HEAD];

   wire [BUS_W-1:0] bus_mask = sel_ctrl ? MASK_CTRL :
      sel_diff ? MASK_FULL :
      (sel_head | sel_sect) ? MASK_ADDR : MASK_FULL;
   wire [BUS_W-1:0] bus_next = bus_raw & bus_mask;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_ctrl_bus_out <= '0;
         unit_select_out <= '0;
         head_tag_out <= 1'b0;
         sector_tag_out <= 1'b0;
         diff_tag_out <= 1'b0;
         ctrl_tag_out <= 1'b0;
      end else begin
         addr_ctrl_bus_out <= bus_next;
         unit_select_out <= unit_code;
         head_tag_out <= sel_head;
         sector_tag_out <= sel_sect;
         diff_tag_out <= sel_diff;
         ctrl_tag_out <= sel_ctrl;
      end
   end

   // ************************************************
   // Serial word engine
   // ************************************************
   dkc_state_t state;
   dkc_state_t next_state;
   logic [WORD_W-1:0] shreg;
   logic [3:0] bit_cnt;

   wire last_bit = (bit_cnt == 4'hf);

   always_comb begin
      next_state = state;
      case (state)
         DKC_IDLE: begin
            if (write_mode) begin
               next_state = DKC_WRITE;
            end else if (zsearch) begin
               next_state = DKC_HUNT;
            end
         end
         DKC_HUNT: begin
            if (write_mode) begin
               next_state = DKC_WRITE;
            end else if (bit_stb && rd_bit) begin
               next_state = DKC_READ;
            end
         end
         DKC_READ: begin
            if (write_mode) begin
               next_state = DKC_WRITE;
            end else if (zsearch) begin
               next_state = DKC_HUNT;
            end
         end
         DKC_WRITE: begin
            if (!write_mode) begin
               next_state = DKC_IDLE;
            end
         end
         default: begin
            next_state = DKC_IDLE;
         end
      endcase
   end

   wire in_read = (state == DKC_READ);
   wire in_write = (state == DKC_WRITE);
   wire enter_write = ~in_write & (next_state == DKC_WRITE);
   wire rd_done = in_read & ~zsearch & ~write_mode & bit_stb & last_bit;
   wire wr_done = in_write & write_mode & bit_stb & last_bit;
   wire [WORD_W-1:0] rd_assembled = {shreg[WORD_W-2:0], rd_bit};
   wire word_done = rd_done | wr_done | enter_write;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= DKC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Shift register: loads complement on write, fills MSB first on read
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shreg <= '0;
         bit_cnt <= '0;
      end else if (enter_write || wr_done) begin
         shreg <= ~write_word_in;
         bit_cnt <= '0;
      end else if (in_write && bit_stb) begin
         shreg <= {shreg[WORD_W-2:0], 1'b0};
         bit_cnt <= bit_cnt + 4'h1;
      end else if (in_read && bit_stb) begin
         shreg <= rd_assembled;
         bit_cnt <= bit_cnt + 4'h1;
      end else if (!in_read && !in_write) begin
         bit_cnt <= '0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         read_word_out <= '0;
         write_data_out <= 1'b0;
      end else begin
         if (rd_done) begin
            read_word_out <= rd_assembled;
         end
         write_data_out <= in_write & shreg[WORD_W-1];
      end
   end

   // ************************************************
   // Flag, mark and on-sector timers
   // ************************************************
   dkc_tmr_if flag_if ();
   dkc_tmr_if smark_if ();
   dkc_tmr_if imark_if ();
   dkc_tmr_if onsec_if ();

   assign flag_if.start = word_done;
   assign flag_if.clear = rst_flag;
   assign flag_if.hold = 1'b0;
   assign smark_if.start = smark_rise;
   assign smark_if.clear = 1'b0;
   assign smark_if.hold = hold_sm;
   assign imark_if.start = imark_rise;
   assign imark_if.clear = 1'b0;
   assign imark_if.hold = hold_im;
   assign onsec_if.start = onsec_rise;
   assign onsec_if.clear = 1'b0;
   assign onsec_if.hold = 1'b0;

   dkc_timer #(.CYCLES(FLAG_CYCLES)) u_flag_tmr (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tmr(flag_if.timer)
   );

   dkc_timer #(.CYCLES(MARK_CYCLES)) u_smark_tmr (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tmr(smark_if.timer)
   );

   dkc_timer #(.CYCLES(MARK_CYCLES)) u_imark_tmr (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tmr(imark_if.timer)
   );

   dkc_timer #(.CYCLES(ONSEC_CYCLES)) u_onsec_tmr (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .tmr(onsec_if.timer)
   );

   // ************************************************
   // Status word assembly
   // ************************************************
   logic [WORD_W-1:0] status_next;

   genvar gi;
   generate
      for (gi = 0; gi < UNITS; gi++) begin : g_unit
         assign status_next[ST_UNIT0 - gi] = sync_b[SY_UNIT + gi];
      end
   endgenerate

   assign status_next[ST_FLAG] = flag_if.busy;
   assign status_next[ST_SMARK] = smark_if.busy;
   assign status_next[ST_IMARK] = imark_if.busy;
   assign status_next[ST_READY] = sync_b[SY_READY];
   assign status_next[ST_SEEKERR] = sync_b[SY_SEEK];
   assign status_next[ST_ONCYL] = sync_b[SY_ONCYL];
   assign status_next[ST_ONSEC] = onsec_if.busy;
   assign status_next[ST_FAULT] = sync_b[SY_FAULT];

   // Status reads zero whenever another device owns the switched channels
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         drive_status_word_out <= '0;
      end else begin
         drive_status_word_out <= chan_on ? status_next : WORD_ZERO;
      end
   end
endmodule

/* File: hw/dkc_pkg.sv */
// Package: channel bit layout, timing counts and states of the disk channel interface
package dkc_pkg;
   // ************************************************
   // Clock and timing
   // ************************************************
   localparam int CLK_MHZ = 25;
   localparam int FLAG_NS = 6200;
   localparam int MARK_NS = 60000;
   localparam int ONSEC_NS = 1000;
   localparam int FLAG_CYC = (FLAG_NS * CLK_MHZ) / 1000;
   localparam int MARK_CYC = (MARK_NS * CLK_MHZ) / 1000;
   localparam int ONSEC_CYC = (ONSEC_NS * CLK_MHZ) / 1000;
   localparam int TMR_W = 12;

   // ************************************************
   // Widths
   // ************************************************
   localparam int WORD_W = 16;
   localparam int UNITS = 8;
   localparam int BUS_W = 8;

   // ************************************************
   // Status word, vector index (channel bit 0 is index 15)
   // ************************************************
   localparam int ST_UNIT0 = 15;
   localparam int ST_FLAG = 7;
   localparam int ST_SMARK = 6;
   localparam int ST_IMARK = 5;
   localparam int ST_READY = 4;
   localparam int ST_SEEKERR = 3;
   localparam int ST_ONCYL = 2;
   localparam int ST_ONSEC = 1;
   localparam int ST_FAULT = 0;

   // ************************************************
   // Control word
   // ************************************************
   localparam int CT_BUS_LSB = 8;
   localparam int CT_RSTFLAG = 7;
   localparam int CT_HOLDSM = 6;
   localparam int CT_HOLDIM = 5;
   localparam int CT_WRITE = 4;
   localparam int CT_ZSEARCH = 3;
   localparam int CT_UNIT_LSB = 0;
   localparam int UNIT_W = 3;

   // ************************************************
   // Tag select word
   // ************************************************
   localparam int TG_SW1 = 7;
   localparam int TG_SW0 = 6;
   localparam int TG_HEAD = 3;
   localparam int TG_DIFF = 2;
   localparam int TG_CTRL = 1;
   localparam int TG_SECT = 0;
   localparam logic [1:0] SW_DISK = 2'h0;

   // ************************************************
   // Bus masks per tag
   // ************************************************
   localparam logic [7:0] MASK_ADDR = 8'h0f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_CTRL = 8'h77;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      DKC_IDLE = 2'b00,
      DKC_HUNT = 2'b01,
      DKC_READ = 2'b10,
      DKC_WRITE = 2'b11
   } dkc_state_t;
endpackage

/* File: hw/dkc_tmr_if.sv */
// Interface: request and status lines between the channel logic and a hold timer
`timescale 1ns/1ps
interface dkc_tmr_if;
   logic start;
   logic clear;
   logic hold;
   logic busy;
   modport timer (input start, input clear, input hold, output busy);
   modport user (output start, output clear, output hold, input busy);
endinterface

/* File: hw/dkc_timer.sv */
// Retriggerable hold timer: busy for a fixed number of cycles after start
`timescale 1ns/1ps
module dkc_timer #(
   parameter int CYCLES = 155
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   dkc_tmr_if.timer tmr
);
   import dkc_pkg::*;

   localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);

   logic [TMR_W-1:0] cnt;
   logic busy;
   wire expired = (cnt == '0);

   assign tmr.busy = busy;

   // Start beats clear so an event in the clearing cycle survives
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= '0;
         busy <= 1'b0;
      end else if (tmr.start) begin
         cnt <= LAST;
         busy <= 1'b1;
      end else if (busy && tmr.clear) begin
         busy <= 1'b0;
      end else if (busy && expired) begin
         busy <= tmr.hold;
      end else if (busy) begin
         cnt <= cnt - TMR_W'(1);
      end
   end
endmodule

/* File: verification/dkc_drive_model.sv */
// Partner model: disk unit serial stream, mark pulses and status lines
`timescale 1ns/1ps
module dkc_drive_model (
   input wire logic ref_clk_in,
   input wire logic [2:0] unit_select_in,
   input wire logic write_data_in,
   output logic [7:0] unit_selected_out,
   output logic [3:0] levels_out,
   output logic [2:0] pulses_out,
   output logic read_data_out,
   output logic bit_clock_out,
   output logic [15:0] wcap_out
);
   assign unit_selected_out = 8'h01 << unit_select_in;
   initial begin
      levels_out = 4'h0;
      pulses_out = 3'h0;
      read_data_out = 1'b0;
      bit_clock_out = 1'b0;
      wcap_out = 16'h0000;
   end
   // Levels: ready, seek error, on cylinder, fault
   task automatic set_levels(input logic [3:0] v);
      levels_out = v;
   endtask
   // Pulses: on sector, index mark, sector mark
   task automatic pulse(input logic [2:0] p);
      @(negedge ref_clk_in);
      pulses_out = p;
      repeat (2) @(negedge ref_clk_in);
      pulses_out = 3'h0;
   endtask
   // Bit clock runs only inside a frame; write line sampled before each strobe
   task automatic bits(input logic [15:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk_in);
         read_data_out = w[15 - i];
         bit_clock_out = 1'b1;
         wcap_out = {wcap_out[14:0], write_data_in};
         repeat (2) @(negedge ref_clk_in);
         bit_clock_out = 1'b0;
         repeat (3) @(negedge ref_clk_in);
      end
      // Released line must not look like the last bit
      read_data_out = ~read_data_out;
   endtask
endmodule

/* File: verification/dkc_top_chk.sv */
// Checker: port timing relations of the disk channel interface
`timescale 1ns/1ps
module dkc_top_chk import dkc_pkg::*; #(
   parameter int FLAG_CYCLES = 8,
   parameter int MARK_CYCLES = 20,
   parameter int ONSEC_CYCLES = 4
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [15:0] tag_select_word_in,
   input wire logic [15:0] drive_control_word_in,
   input wire logic [15:0] drive_status_word_out,
   input wire logic [2:0] unit_select_out,
   input wire logic [7:0] addr_ctrl_bus_out,
   input wire logic head_tag_out,
   input wire logic sector_tag_out,
   input wire logic diff_tag_out,
   input wire logic ctrl_tag_out,
   input wire logic ready_in,
   input wire logic seek_error_in,
   input wire logic on_cylinder_in,
   input wire logic fault_in
);
   // Mark is watched 8 cycles, then must clear in this window
   localparam int MARK_LO = MARK_CYCLES - 11;
   localparam int MARK_HI = MARK_CYCLES - 6;
   logic [2:0] up;
   wire logic [15:0] tg = tag_select_word_in;
   wire logic [15:0] ct = drive_control_word_in;
   wire logic [15:0] st = drive_status_word_out;
   wire logic sw_on = tg[7:6] == SW_DISK;
   wire logic [3:0] tags = {head_tag_out, sector_tag_out, diff_tag_out, ctrl_tag_out};
   wire logic [3:0] lv = {ready_in, seek_error_in, on_cylinder_in, fault_in};
   // Sync stages hold reset values for a few edges after release
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         up <= 3'h0;
      end else if (up != 3'h7) begin
         up <= up + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_held(logic s);
      s [*8];
   endsequence
   property p_mark(logic s, logic h);
      $rose(s) && !h |-> s_held(s) ##[MARK_LO:MARK_HI] !s;
   endproperty
   a_tag_one_hot: assert property ($onehot0(tags)) else $error("several tag lines high");
   a_addr_tag_bus: assert property (sw_on && (tg[TG_HEAD] || tg[TG_SECT]) && tg[2:1] == 2'h0
      |=> (head_tag_out || sector_tag_out) && addr_ctrl_bus_out == ($past(ct[15:8]) & MASK_ADDR))
      else $error("address tag bus wrong");
   a_diff_full_bus: assert property (sw_on && tg[TG_DIFF] && !tg[TG_CTRL] |=> diff_tag_out
      && addr_ctrl_bus_out == $past(ct[15:8])) else $error("difference bus wrong");
   a_ctrl_line_mask: assert property (sw_on && tg[TG_CTRL] |=> ctrl_tag_out
      && addr_ctrl_bus_out == ($past(ct[15:8]) & MASK_CTRL)) else $error("control bus wrong");
   a_switch_off_quiet: assert property ((!sw_on) [*2] |-> st == WORD_ZERO && tags == 4'h0)
      else $error("channels active with switch code set");
   a_unit_code: assert property (sw_on |=> unit_select_out == $past(ct[2:0])) else $error("unit code wrong");
   a_level_lag: assert property ((sw_on && up == 3'h7) [*4] |->
      {st[ST_READY], st[ST_SEEKERR], st[ST_ONCYL], st[ST_FAULT]} == $past(lv, 3)) else $error("level status wrong");
   a_smark_hold: assert property (p_mark(st[ST_SMARK], ct[CT_HOLDSM])) else $error("sector mark time wrong");
   a_imark_hold: assert property (p_mark(st[ST_IMARK], ct[CT_HOLDIM])) else $error("index mark time wrong");
   a_flag_window: assert property ($rose(st[ST_FLAG]) ##1 (!ct[CT_RSTFLAG]) [*5] |->
      st[ST_FLAG] ##[1:3] !st[ST_FLAG]) else $error("flag window wrong");
   a_flag_reset: assert property (st[ST_FLAG] && ct[CT_RSTFLAG] |-> ##[1:3] !st[ST_FLAG])
      else $error("reset flag ignored");
   a_onsec_pulse: assert property ($rose(st[ST_ONSEC]) |-> st[ST_ONSEC] [*3] ##[1:2] !st[ST_ONSEC])
      else $error("on sector pulse wrong");
endmodule

/* File: verification/test_dkc_top.sv */
// Testbench: channel word table, then read, write, flag, mark and reset scenarios
`timescale 1ns/1ps
module test_dkc_top;
   import dkc_pkg::*;
   typedef struct packed {
      logic [15:0] tag;
      logic [7:0] bus;
      logic [7:0] exp_bus;
      logic [3:0] exp_tags;
   } dkc_row_t;
   // Tags order: head, sector, difference, control
   localparam dkc_row_t ROWS [8] = '{'{16'h0008, 8'ha5, 8'h05, 4'h8}, '{16'h0001, 8'h5a, 8'h0a, 4'h4},
      '{16'h0004, 8'hc3, 8'hc3, 4'h2}, '{16'h0002, 8'hff, 8'h77, 4'h1}, '{16'h000e, 8'h88, 8'h00, 4'h1},
      '{16'h0048, 8'hff, 8'h00, 4'h0}, '{16'h0088, 8'hff, 8'h00, 4'h0}, '{16'h00c2, 8'hff, 8'h00, 4'h0}};
   logic clk, rst;
   logic [15:0] tag_w, ctl_w, wr_w;
   logic [3:0] lx;
   wire logic [15:0] st, rd, wcap;
   wire logic [7:0] bus, sel;
   wire logic [3:0] tags, lv;
   wire logic [2:0] unit, pl;
   wire logic wdat, rdat, bclk;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   dkc_top #(.FLAG_CYCLES(8), .MARK_CYCLES(20), .ONSEC_CYCLES(4)) u_dut (.ref_clk_in(clk), .rst_in(rst),
      .tag_select_word_in(tag_w), .drive_control_word_in(ctl_w), .write_word_in(wr_w),
      .drive_status_word_out(st), .read_word_out(rd), .unit_select_out(unit), .addr_ctrl_bus_out(bus),
      .head_tag_out(tags[3]), .sector_tag_out(tags[2]), .diff_tag_out(tags[1]), .ctrl_tag_out(tags[0]),
      .write_data_out(wdat), .unit_selected_in(sel), .ready_in(lv[3]), .seek_error_in(lv[2]),
      .on_cylinder_in(lv[1]), .on_sector_in(pl[2]), .fault_in(lv[0]), .sector_mark_in(pl[0]),
      .index_mark_in(pl[1]), .read_data_in(rdat), .bit_clock_in(bclk));
   dkc_drive_model u_drv (.ref_clk_in(clk), .unit_select_in(unit), .write_data_in(wdat),
      .unit_selected_out(sel), .levels_out(lv), .pulses_out(pl), .read_data_out(rdat),
      .bit_clock_out(bclk), .wcap_out(wcap));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask
   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic waitn(input int n);
      repeat (n) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // A hang is cut short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      rst = 1'b1;
      tag_w = 16'h0000;
      ctl_w = 16'h0000;
      wr_w = 16'hffff;
      waitn(5);
      chk("rst_status", 16'h0000, st);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         lx = 4'(i + 9);
         tag_w = ROWS[i].tag;
         ctl_w = {ROWS[i].bus, 5'h00, 3'(i)};
         u_drv.set_levels(lx);
         waitn(5);
         chk("bus", {8'h00, ROWS[i].exp_bus}, {8'h00, bus});
         chk("tags", {12'h000, ROWS[i].exp_tags}, {12'h000, tags});
         chk("unit", (ROWS[i].tag[7:6] != 2'h0) ? 16'h0000 : 16'(i[2:0]), {13'h0000, unit});
         chk("status", (ROWS[i].tag[7:6] != 2'h0) ? 16'h0000 : {8'h80 >> i, 3'h0, lx[3:1], 1'b0, lx[0]}, st);
      end
      // Seek, then head and sector select, as the controller sequences them
      ctl_w = 16'h2500;
      tag_w = 16'h0004;
      waitn(2);
      chk("seek_diff", 16'h0025, {8'h00, bus});
      tag_w = 16'h0000;
      ctl_w = 16'h0000;
      waitn(2);
      chk("seek_idle", 16'h0000, {12'h000, tags});
      ctl_w = 16'h0400;
      tag_w = 16'h0002;
      waitn(2);
      chk("seek_ctrl", 16'h0401, {bus, 4'h0, tags});
      tag_w = 16'h0000;
      ctl_w = 16'h0000;
      u_drv.set_levels(4'h2);
      waitn(5);
      chk("on_cyl", 16'h0001, 16'(st[ST_ONCYL]));
      ctl_w = 16'h0300;
      tag_w = 16'h0008;
      waitn(2);
      chk("head_sel", 16'h0308, {bus, 4'h0, tags});
      ctl_w = 16'h0700;
      tag_w = 16'h0001;
      waitn(2);
      chk("sect_sel", 16'h0704, {bus, 4'h0, tags});
      // Read: zeros search armed, preamble zeros, sync bit, two words
      tag_w = 16'h0000;
      ctl_w = 16'h0008;
      wr_w = 16'hffff;
      waitn(3);
      ctl_w = 16'h0000;
      u_drv.bits(16'h0000, 4);
      chk("hunt_flag", 16'h0000, 16'(st[ST_FLAG]));
      u_drv.bits(16'h8000, 1);
      u_drv.bits(16'ha53c, 16);
      waitn(2);
      chk("word1", 16'ha53c, rd);
      chk("flag1", 16'h0001, 16'(st[ST_FLAG]));
      u_drv.bits(16'h1234, 16);
      waitn(2);
      chk("word2", 16'h1234, rd);
      ctl_w = 16'h0080;
      waitn(3);
      chk("flag_reset", 16'h0000, 16'(st[ST_FLAG]));
      // Write: entry load, then the next word before the 16th strobe
      ctl_w = 16'h0010;
      wr_w = 16'hc35a;
      waitn(2);
      chk("wflag1", 16'h0001, 16'(st[ST_FLAG]));
      wr_w = 16'h0ff0;
      u_drv.bits(16'h0000, 16);
      waitn(1);
      chk("wword1", ~16'hc35a, wcap);
      chk("wflag2", 16'h0001, 16'(st[ST_FLAG]));
      u_drv.bits(16'h0000, 16);
      chk("wword2", ~16'h0ff0, wcap);
      ctl_w = 16'h0000;
      // Marks: single, with index, then held by the hold bits
      u_drv.pulse(3'h1);
      waitn(4);
      chk("smark", 16'h0001, 16'(st[ST_SMARK]));
      waitn(30);
      chk("smark_clr", 16'h0000, 16'(st[ST_SMARK]));
      u_drv.pulse(3'h3);
      waitn(4);
      chk("imark", 16'h0003, {14'h0000, st[ST_SMARK], st[ST_IMARK]});
      waitn(30);
      ctl_w = 16'h0060;
      u_drv.pulse(3'h3);
      waitn(40);
      chk("held", 16'h0003, {14'h0000, st[ST_SMARK], st[ST_IMARK]});
      ctl_w = 16'h0000;
      waitn(3);
      chk("freed", 16'h0000, {14'h0000, st[ST_SMARK], st[ST_IMARK]});
      u_drv.pulse(3'h4);
      waitn(4);
      chk("onsec", 16'h0001, 16'(st[ST_ONSEC]));
      waitn(8);
      chk("onsec_end", 16'h0000, 16'(st[ST_ONSEC]));
      // Second reset in mid-run clears held words
      u_drv.set_levels(4'hf);
      waitn(5);
      rst = 1'b1;
      waitn(2);
      chk("rst2_status", 16'h0000, st);
      chk("rst2_read", 16'h0000, rd);
      rst = 1'b0;
      waitn(2);
      summarize();
   end
endmodule
bind dkc_top dkc_top_chk #(.FLAG_CYCLES(FLAG_CYCLES), .MARK_CYCLES(MARK_CYCLES), .ONSEC_CYCLES(ONSEC_CYCLES))
   u_chk (.ref_clk_in, .rst_in, .tag_select_word_in, .drive_control_word_in, .drive_status_word_out,
   .unit_select_out, .addr_ctrl_bus_out, .head_tag_out, .sector_tag_out, .diff_tag_out, .ctrl_tag_out,
   .ready_in, .seek_error_in, .on_cylinder_in, .fault_in);
